// ==== gpc_defines.vh ====
// offsets, reset values and field codes of the pad configuration block
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH
`define GPC_OFF_DRV_TYPE   8'h04
`define GPC_OFF_SLEW       8'h08
`define GPC_OFF_PULL       8'h0C
`define GPC_OFF_LEVELS     8'h10
`define GPC_RST_DRV_TYPE   16'h0000
`define GPC_RST_SLEW_A     32'h00000030
`define GPC_RST_SLEW_B     32'h00000000
`define GPC_RST_PULL_A     32'h55555595
`define GPC_RST_PULL_B     32'h55555555
`define GPC_PULL_NONE      2'h0
`define GPC_PULL_UP        2'h1
`define GPC_PULL_DOWN      2'h2
`define GPC_FN_INPUT       2'h0
`define GPC_FN_OUTPUT      2'h1
`define GPC_FN_ALT         2'h2
`define GPC_FN_ANALOG      2'h3
`define GPC_APC_BIT        4
`endif

// ==== gpc_pad_cell.v ====
// per-pin pad control decode: driver enables, pulls, input gating
`timescale 1ns/1ps
`include "gpc_defines.vh"
module gpc_pad_cell (
	input  wire [1:0] i_pin_function_field,
	input  wire       i_driver_type_bit,
	input  wire       i_output_value_bit,
	input  wire       i_alt_out,
	input  wire       i_alt_oe,
	input  wire [1:0] i_pull_select_field,
	input  wire       i_pull_allowed,
	input  wire       i_level,
	output wire       o_high_drv,
	output wire       o_low_drv,
	output wire       o_pull_up,
	output wire       o_pull_down,
	output wire       o_level
);
	wire is_out = (i_pin_function_field == `GPC_FN_OUTPUT);
	wire is_alt = (i_pin_function_field == `GPC_FN_ALT);
	wire val    = is_alt ? i_alt_out : i_output_value_bit;
	wire en     = is_out | (is_alt & i_alt_oe);
	assign o_low_drv   = en & ~val;
	assign o_high_drv  = en & val & ~i_driver_type_bit;
	assign o_pull_up   = i_pull_allowed & (i_pull_select_field == `GPC_PULL_UP);
	assign o_pull_down = i_pull_allowed & (i_pull_select_field == `GPC_PULL_DOWN);
	assign o_level     = (i_pin_function_field == `GPC_FN_ANALOG) ? 1'b0 : i_level;
endmodule // gpc_pad_cell

// ==== gpc_pad_config.v ====
// pad configuration and input level registers of a 16-pin port
//
// Overview of operation
// - offset 0x04 holds one driver type bit per pin, 0 push-pull (reset), 1 open-drain.
// - bits 31:16 of this register are reserved, read zero and ignore writes.
// - offset 0x08 holds a 2-bit slew speed field per pin, reset 0x30 on port A, 0 on B.
// - offset 0x0C holds a 2-bit pull field per pin: 00 none, 01 up, 10 down, 11 reserved.
// - the pull register resets to 0x55555595 on port A and 0x55555555 on port B.
// - with the auto pull control bit set the pull register applies no pull.
// - with auto pull control clear, pulls apply only in run mode, not in low power.
// - offset 0x10 is read only and its low 16 bits show the current pin levels.
// - after reset the input bits are unknown until sampled (here they reset to zero); the upper half reads zero.
// - pin levels are sampled into the input register every clock in all digital modes.
// - open-drain drives low for 0 and floats for 1; the high driver never turns on.
// - the pin function field selects input, output, alternate, analog; analog reads 0.
// - writes of word, half-word or byte width update only the addressed bytes.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "gpc_defines.vh"
module gpc_pad_config #(
	parameter       PINS   = 16,
	parameter       PORT_A = 1
) (
	input  wire              i_mclk,
	input  wire              i_sys_rst,
	input  wire [7:0]        i_addr,
	input  wire [31:0]       i_wdata,
	input  wire [3:0]        i_wbe,
	input  wire              i_wr,
	input  wire              i_rd,
	output reg  [31:0]       o_rdata,
	input  wire [2*PINS-1:0] i_pin_function_field,
	input  wire [PINS-1:0]   i_output_value_bit,
	input  wire [PINS-1:0]   i_alt_out,
	input  wire [PINS-1:0]   i_alt_oe,
	input  wire [31:0]       i_power_control_reg1,
	input  wire              i_low_power,
	input  wire [PINS-1:0]   i_pad_level,
	output reg  [PINS-1:0]   o_pad_high_drv,
	output reg  [PINS-1:0]   o_pad_low_drv,
	output reg  [PINS-1:0]   o_pad_pull_up,
	output reg  [PINS-1:0]   o_pad_pull_down,
	output reg  [2*PINS-1:0] o_slew_speed_field
);
	// ****************************************************************
	// registers
	// ****************************************************************
	reg  [15:0] drv_type_q;
	reg  [31:0] slew_q;
	reg  [31:0] pull_q;
	reg  [15:0] levels_q;
	wire [31:0] bmask = {{8{i_wbe[3]}}, {8{i_wbe[2]}}, {8{i_wbe[1]}}, {8{i_wbe[0]}}};
	always @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			drv_type_q <= `GPC_RST_DRV_TYPE;
			slew_q     <= PORT_A ? `GPC_RST_SLEW_A : `GPC_RST_SLEW_B;
			pull_q     <= PORT_A ? `GPC_RST_PULL_A : `GPC_RST_PULL_B;
		end else if (i_wr) begin
			case (i_addr)
				`GPC_OFF_DRV_TYPE: begin
					drv_type_q <= (drv_type_q & ~bmask[15:0]) | (i_wdata[15:0] & bmask[15:0]);
				end
				`GPC_OFF_SLEW: begin
					slew_q <= (slew_q & ~bmask) | (i_wdata & bmask);
				end
				`GPC_OFF_PULL: begin
					pull_q <= (pull_q & ~bmask) | (i_wdata & bmask);
				end
				default: begin
					drv_type_q <= drv_type_q;
				end
			endcase
		end
	end
	// ****************************************************************
	// pin sampling
	// ****************************************************************
	wire [15:0] sync_lvl;
	wire [15:0] gated_lvl;
	gpc_sync2 #(.W(16)) u_sync (
		.i_mclk   (i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_async  (i_pad_level),
		.o_sync   (sync_lvl)
	);
	always @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			levels_q <= 16'h0000;
		end else begin
			levels_q <= gated_lvl;
		end
	end
	// ****************************************************************
	// pad control
	// ****************************************************************
	wire pull_ok = ~i_power_control_reg1[`GPC_APC_BIT] & ~i_low_power;
	wire [15:0] hd;
	wire [15:0] ld;
	wire [15:0] pu;
	wire [15:0] pd;
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_pin
			gpc_pad_cell u_cell (
				.i_pin_function_field(i_pin_function_field[2*g+1:2*g]),
				.i_driver_type_bit   (drv_type_q[g]),
				.i_output_value_bit  (i_output_value_bit[g]),
				.i_alt_out           (i_alt_out[g]),
				.i_alt_oe            (i_alt_oe[g]),
				.i_pull_select_field (pull_q[2*g+1:2*g]),
				.i_pull_allowed      (pull_ok),
				.i_level             (sync_lvl[g]),
				.o_high_drv          (hd[g]),
				.o_low_drv           (ld[g]),
				.o_pull_up           (pu[g]),
				.o_pull_down         (pd[g]),
				.o_level             (gated_lvl[g])
			);
		end
	endgenerate
	always @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_pad_high_drv     <= 16'h0000;
			o_pad_low_drv      <= 16'h0000;
			o_pad_pull_up      <= 16'h0000;
			o_pad_pull_down    <= 16'h0000;
			o_slew_speed_field <= 32'h00000000;
		end else begin
			o_pad_high_drv     <= hd;
			o_pad_low_drv      <= ld;
			o_pad_pull_up      <= pu;
			o_pad_pull_down    <= pd;
			o_slew_speed_field <= slew_q;
		end
	end
	// ****************************************************************
	// read path
	// ****************************************************************
	always @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rdata <= 32'h00000000;
		end else if (i_rd) begin
			case (i_addr)
				`GPC_OFF_DRV_TYPE: o_rdata <= {16'h0000, drv_type_q};
				`GPC_OFF_SLEW:     o_rdata <= slew_q;
				`GPC_OFF_PULL:     o_rdata <= pull_q;
				`GPC_OFF_LEVELS:   o_rdata <= {16'h0000, levels_q};
				default:           o_rdata <= 32'h00000000;
			endcase
		end else begin
			o_rdata <= 32'h00000000;
		end
	end
endmodule // gpc_pad_config

// ==== gpc_pad_config_sva.sv ====
// port checker of the pad configuration block
`timescale 1ns/1ps
module gpc_pad_config_sva #(parameter PINS = 16, parameter PORT_A = 1) (
	input wire        i_mclk, i_sys_rst, i_wr, i_rd, i_low_power,
	input wire [7:0]  i_addr,
	input wire [3:0]  i_wbe,
	input wire [31:0] i_wdata, o_rdata, i_power_control_reg1,
	input wire [31:0] i_pin_function_field, o_slew_speed_field,
	input wire [15:0] i_output_value_bit, i_alt_out, i_alt_oe, i_pad_level,
	input wire [15:0] o_pad_high_drv, o_pad_low_drv, o_pad_pull_up, o_pad_pull_down
);
	// ****
	// properties
	// ****
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	sequence s_rd(a); i_rd && i_addr == a; endsequence
	sequence s_ana; (i_pin_function_field == 32'hFFFFFFFF) [*5]; endsequence
	property p_idle; !i_rd |=> o_rdata == 32'h0; endproperty
	property p_drv_hi; s_rd(8'h04) |=> o_rdata[31:16] == 16'h0; endproperty
	property p_lvl_hi; s_rd(8'h10) |=> o_rdata[31:16] == 16'h0; endproperty
	property p_apc; i_power_control_reg1[4] [*2] |-> (o_pad_pull_up | o_pad_pull_down) == 16'h0;
	endproperty
	property p_lp; i_low_power [*2] |-> (o_pad_pull_up | o_pad_pull_down) == 16'h0; endproperty
	property p_pull; (o_pad_pull_up & o_pad_pull_down) == 16'h0; endproperty
	property p_drv; (o_pad_high_drv & o_pad_low_drv) == 16'h0; endproperty
	property p_ana; s_ana ##0 s_rd(8'h10) |=> o_rdata == 32'h0; endproperty
	property p_slew; $past(i_sys_rst) && !i_sys_rst |-> ##1
		o_slew_speed_field == (PORT_A ? 32'h30 : 32'h0); endproperty
	a_idle: assert property (p_idle) else $error("read data outside read slot");
	a_drv_hi: assert property (p_drv_hi) else $error("type upper half set");
	a_lvl_hi: assert property (p_lvl_hi) else $error("level upper half set");
	a_apc: assert property (p_apc) else $error("pull with auto control");
	a_lp: assert property (p_lp) else $error("pull in low power");
	a_pull: assert property (p_pull) else $error("pull up and down");
	a_drv: assert property (p_drv) else $error("both drivers on");
	a_ana: assert property (p_ana) else $error("analog pin reads one");
	a_slew: assert property (p_slew) else $error("speed reset value");
endmodule // gpc_pad_config_sva
bind gpc_pad_config gpc_pad_config_sva #(.PINS(PINS), .PORT_A(PORT_A)) u_sva (.*);

// ==== gpc_pad_model.sv ====
// behavioural model of the sixteen pads
`timescale 1ns/1ps
module gpc_pad_model (
	input  wire         i_mclk,
	input  wire  [15:0] i_high,
	input  wire  [15:0] i_low,
	input  wire  [15:0] i_pu,
	input  wire  [15:0] i_pd,
	input  wire  [15:0] i_ext,
	input  wire  [15:0] i_ext_en,
	output logic [15:0] o_level
);
	// ****
	// pad level
	// ****
	logic flt_q = 1'b0;
	// floating pads toggle so nothing passes by luck
	always @(posedge i_mclk) flt_q <= ~flt_q;
	always_comb for (int i = 0; i < 16; i++) o_level[i] = i_low[i] ? 1'b0 : i_high[i] ? 1'b1 :
		i_ext_en[i] ? i_ext[i] : i_pu[i] ? 1'b1 : i_pd[i] ? 1'b0 : flt_q;
endmodule // gpc_pad_model

// ==== gpc_sync2.v ====
// two flip-flop synchroniser for a vector of pad levels
`timescale 1ns/1ps
module gpc_sync2 #(
	parameter W = 16
) (
	input  wire         i_mclk,
	input  wire         i_sys_rst,
	input  wire [W-1:0] i_async,
	output reg  [W-1:0] o_sync
);
	reg [W-1:0] meta_q;
	always @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta_q <= {W{1'b0}};
			o_sync <= {W{1'b0}};
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule // gpc_sync2

// ==== tb.sv ====
// testbench of the pad configuration block
`timescale 1ns/1ps
module tb;
	// ****
	// bench
	// ****
	logic i_mclk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_low_power = 0;
	logic [7:0]  i_addr = 0;
	logic [3:0]  i_wbe = 0;
	logic [31:0] i_wdata = 0, i_power_control_reg1 = 0, i_pin_function_field = 0;
	logic [15:0] i_output_value_bit = 0, i_alt_out = 0, i_alt_oe = 0, ext = 0, ext_en = 0;
	wire  [31:0] o_rdata, o_slew_speed_field;
	wire  [15:0] o_pad_high_drv, o_pad_low_drv, o_pad_pull_up, o_pad_pull_down, i_pad_level;
	int fails = 0, cmp_count = 0;
	gpc_pad_config #(.PINS(16), .PORT_A(1)) u_dut (.*);
	gpc_pad_model u_pads (.i_mclk(i_mclk), .i_high(o_pad_high_drv), .i_low(o_pad_low_drv),
		.i_pu(o_pad_pull_up), .i_pd(o_pad_pull_down), .i_ext(ext), .i_ext_en(ext_en),
		.o_level(i_pad_level));
	always #2 i_mclk = ~i_mclk;
	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [3:0] be);
		@(posedge i_mclk);
		{i_wr, i_addr, i_wdata, i_wbe} <= {1'b1, a, d, be};
		@(posedge i_mclk);
		i_wr <= 0;
	endtask
	task rd(input [7:0] a, input [31:0] exp);
		@(posedge i_mclk);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_mclk);
		i_rd <= 0;
		#1 chk(o_rdata, exp);
	endtask
	function [31:0] merge(input [31:0] o, input [31:0] n, input [3:0] be);
		for (int b = 0; b < 4; b++) if (be[b]) o[8*b +: 8] = n[8*b +: 8];
		return o;
	endfunction
	function [15:0] pm(input [31:0] p, input [1:0] c, input off);
		for (int i = 0; i < 16; i++) pm[i] = !off && p[2*i +: 2] == c;
	endfunction
	initial begin
		repeat (20000) @(posedge i_mclk);
		fails++;
		results;
	end
	initial begin
		logic [31:0] m [3];
		logic [31:0] d;
		logic [3:0]  be;
		logic [15:0] t;
		logic [15:0] v;
		int r;
		m = '{32'h0, 32'h30, 32'h55555595};
		void'($urandom(32'h1f81));
		repeat (4) @(posedge i_mclk);
		i_sys_rst <= 0;
		repeat (6) @(posedge i_mclk);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h30);
		rd(8'h0C, 32'h55555595);
		rd(8'h10, 32'hFFF7);
		rd(8'h14, 32'h0);
		for (int k = 0; k < 30; k++) begin
			r = k % 3;
			d = $urandom;
			be = (k < 3) ? 4'hF : 4'($urandom);
			// no reserved pull code
			if (r == 2) d = d & ~((d << 1) & 32'hAAAAAAAA);
			m[r] = merge(m[r], d, be) & (r == 0 ? 32'hFFFF : 32'hFFFFFFFF);
			wr(8'h04 + 8'(4 * r), d, be);
			rd(8'h04 + 8'(4 * r), m[r]);
		end
		chk(o_slew_speed_field, m[1]);
		for (int c = 0; c < 4; c++) begin
			i_power_control_reg1 <= ($urandom & ~32'h10) | (c[0] ? 32'h10 : 32'h0);
			i_low_power <= c[1];
			repeat (3) @(posedge i_mclk);
			#1;
			chk({o_pad_pull_up, o_pad_pull_down}, {pm(m[2], 2'h1, c != 0), pm(m[2], 2'h2, c != 0)});
		end
		{i_power_control_reg1, i_low_power, ext_en} <= {32'h0, 1'b0, 16'hFFFF};
		for (int k = 0; k < 8; k++) begin
			ext <= 16'($urandom);
			i_pin_function_field <= (k == 7) ? 32'hFFFFFFFF : $urandom & 32'hAAAAAAAA;
			repeat (5) @(posedge i_mclk);
			wr(8'h10, $urandom, 4'hF);
			rd(8'h10, (k == 7) ? 32'h0 : {16'h0, ext});
		end
		{ext_en, i_pin_function_field} <= {16'h0, 32'h55555555};
		for (int k = 0; k < 4; k++) begin
			t = (k < 2) ? {16{k[0]}} : 16'($urandom);
			wr(8'h04, {16'h0, t}, 4'h3);
			v = 16'($urandom);
			i_output_value_bit <= v;
			repeat (3) @(posedge i_mclk);
			#1;
			chk({o_pad_low_drv, o_pad_high_drv}, {~v, v & ~t});
		end
		results;
	end
endmodule // tb
